/* File: verilog/clpm_top.sv */
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module clpm_top #(
    parameter int SLEEP0_MS = 1000,
    parameter int SLEEP1_MS = 2000,
    parameter int SLEEP2_MS = 3000,
    parameter int SLEEP3_MS = 4000,
    parameter int WAKE_MS = 100,
    parameter int LTO0_MS = 1000,
    parameter int LTO1_MS = 2000,
    parameter int LTO2_MS = 3000,
    parameter int LTO3_MS = 4000,
    parameter int SEARCH_MS = 500,
    parameter int BURST_MS = 16,
    parameter int MS_DIV = clpm_pkg::MS_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic energy_in,
    input wire logic loopback_in,
    input wire logic link_up_in,
    output logic blocks_on,
    output logic flp_send,
    output logic flp_pair_b,
    output logic det_flp_send,
    output logic an_run,
    output logic [1:0] pwr_state
);
    // ------------------------------------------------------------
    // Synchronisers and millisecond tick
    // ------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic energy;
    logic loopback;
    logic link_up;
    logic ms_tick;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {link_up_in, loopback_in, energy_in};
            sync2_q <= sync1_q;
        end
    end

    assign energy = sync2_q[0];
    assign loopback = sync2_q[1];
    assign link_up = sync2_q[2];

    clpm_ms_tick #(
        .DIV(MS_DIV)
    ) u_tick (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .tick(ms_tick)
    );

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    clpm_pkg::clpm_cfg_t cfg_q;
    logic [1:0] det_stat_q;
    logic det_irq_q;
    logic det_irq_set;
    logic wr;
    logic rd;

    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == clpm_pkg::CTRL_OFF) || (a == clpm_pkg::STAT_OFF)
            || (a == clpm_pkg::DET_OFF) || (a == clpm_pkg::PDI_OFF)
            || (a == clpm_pkg::TMR_OFF);
    endfunction

    assign pslverr = psel && penable && !mapped(paddr);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cfg_q.an_en <= clpm_pkg::CTRL_RST[clpm_pkg::CTRL_AN_EN];
            cfg_q.pwr_dn <= clpm_pkg::CTRL_RST[clpm_pkg::CTRL_PWR_DN];
            cfg_q.apd_en <= clpm_pkg::CTRL_RST[clpm_pkg::CTRL_APD_EN];
            cfg_q.lto_sel <= 2'h0;
            cfg_q.det_en <= 1'b0;
            cfg_q.sleep_sel <= clpm_pkg::TMR_RST[clpm_pkg::TMR_SLEEP_LSB +: 2];
            cfg_q.wake_sel <= clpm_pkg::TMR_RST[clpm_pkg::TMR_WAKE_LSB +: 2];
        end else if (wr) begin
            if (paddr == clpm_pkg::CTRL_OFF) begin
                cfg_q.an_en <= pwdata[clpm_pkg::CTRL_AN_EN];
                cfg_q.pwr_dn <= pwdata[clpm_pkg::CTRL_PWR_DN];
                cfg_q.apd_en <= pwdata[clpm_pkg::CTRL_APD_EN];
                cfg_q.lto_sel <= {pwdata[clpm_pkg::CTRL_LTO_HI],
                    pwdata[clpm_pkg::CTRL_LTO_LO]};
            end else if (paddr == clpm_pkg::DET_OFF) begin
                cfg_q.det_en <= pwdata[clpm_pkg::DET_EN];
            end else if (paddr == clpm_pkg::TMR_OFF) begin
                cfg_q.sleep_sel <= pwdata[clpm_pkg::TMR_SLEEP_LSB +: 2];
                cfg_q.wake_sel <= pwdata[clpm_pkg::TMR_WAKE_LSB +: 2];
            end
        end
    end

    // Set wins over read-clear so no detection is lost
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            det_irq_q <= 1'b0;
        end else if (det_irq_set) begin
            det_irq_q <= 1'b1;
        end else if (rd && paddr == clpm_pkg::PDI_OFF) begin
            det_irq_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == clpm_pkg::CTRL_OFF) begin
                prdata <= 32'({cfg_q.an_en, cfg_q.pwr_dn, 3'h0, cfg_q.lto_sel[1],
                    cfg_q.apd_en, 3'h0, cfg_q.lto_sel[0], 2'h0});
            end else if (paddr == clpm_pkg::STAT_OFF) begin
                prdata <= 32'({link_up, 2'h0});
            end else if (paddr == clpm_pkg::DET_OFF) begin
                prdata <= 32'({cfg_q.det_en, det_stat_q, 8'h0});
            end else if (paddr == clpm_pkg::PDI_OFF) begin
                prdata <= 32'({det_irq_q, 9'h0});
            end else if (paddr == clpm_pkg::TMR_OFF) begin
                prdata <= 32'({cfg_q.sleep_sel, cfg_q.wake_sel, 11'h0});
            end else begin
                prdata <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Powered-device detection sequencer
    // ------------------------------------------------------------
    logic [15:0] search_q;
    logic det_active;
    logic an_seen_q;

    // Host keeps auto-negotiation on while detecting
    assign det_active = cfg_q.det_en && cfg_q.an_en;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            det_stat_q <= clpm_pkg::DET_SEARCH;
            search_q <= '0;
        end else if (!det_active) begin
            det_stat_q <= clpm_pkg::DET_SEARCH;
            search_q <= '0;
        end else if (det_stat_q == clpm_pkg::DET_SEARCH) begin
            if (loopback) begin
                det_stat_q <= clpm_pkg::DET_FOUND;
            end else if (search_q == 16'(SEARCH_MS)) begin
                det_stat_q <= clpm_pkg::DET_NONE;
            end else if (ms_tick) begin
                search_q <= search_q + 16'h1;
            end
        end else if (det_stat_q == clpm_pkg::DET_NONE && an_seen_q && !link_up) begin
            det_stat_q <= clpm_pkg::DET_SEARCH;
            search_q <= '0;
        end
    end

    // Remember that a link came up so only a real failure restarts detection
    always_ff @(posedge core_clk) begin
        if (!reset_n || det_stat_q != clpm_pkg::DET_NONE) begin
            an_seen_q <= 1'b0;
        end else if (link_up) begin
            an_seen_q <= 1'b1;
        end
    end

    assign det_irq_set = det_active && det_stat_q == clpm_pkg::DET_SEARCH && loopback;
    assign det_flp_send = det_active && det_stat_q == clpm_pkg::DET_SEARCH;
    assign an_run = cfg_q.an_en && !cfg_q.pwr_dn
        && (!det_active || det_stat_q == clpm_pkg::DET_NONE);

    // ------------------------------------------------------------
    // Automatic power-down state machine
    // ------------------------------------------------------------
    clpm_pkg::clpm_pwr_t st_q;
    logic [15:0] tmr_q;
    logic [15:0] sleep_ms;
    logic [15:0] lto_ms;
    logic [15:0] lfsr_q;
    logic [1:0] burst_q;
    logic forced_hold_q;

    function automatic logic [15:0] pick(input logic [1:0] s, input int a,
            input int b, input int c, input int d);
        case (s)
            2'h0: pick = 16'(a);
            2'h1: pick = 16'(b);
            2'h2: pick = 16'(c);
            default: pick = 16'(d);
        endcase
    endfunction

    // Random offset in 0..140 shifted by -80 ms
    assign sleep_ms = pick(cfg_q.sleep_sel, SLEEP0_MS, SLEEP1_MS, SLEEP2_MS, SLEEP3_MS)
        + 16'(lfsr_q[7:0] % 8'(clpm_pkg::JIT_NEG_MS + clpm_pkg::JIT_POS_MS + 1))
        - 16'(clpm_pkg::JIT_NEG_MS);
    assign lto_ms = pick(cfg_q.lto_sel, LTO0_MS, LTO1_MS, LTO2_MS, LTO3_MS);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lfsr_q <= 16'hace1;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_q <= clpm_pkg::CLPM_LOW;
            tmr_q <= '0;
            burst_q <= '0;
            forced_hold_q <= 1'b0;
        end else if (!cfg_q.apd_en) begin
            st_q <= clpm_pkg::CLPM_NORMAL;
            tmr_q <= '0;
            forced_hold_q <= 1'b0;
        end else begin
            case (st_q)
                clpm_pkg::CLPM_LOW: begin
                    if (energy) begin
                        st_q <= clpm_pkg::CLPM_NORMAL;
                        tmr_q <= '0;
                        forced_hold_q <= !cfg_q.an_en;
                    end else if (tmr_q >= sleep_ms) begin
                        st_q <= clpm_pkg::CLPM_WAKE;
                        tmr_q <= '0;
                        burst_q <= '0;
                    end else if (ms_tick) begin
                        tmr_q <= tmr_q + 16'h1;
                    end
                end
                clpm_pkg::CLPM_WAKE: begin
                    if (energy) begin
                        st_q <= clpm_pkg::CLPM_NORMAL;
                        tmr_q <= '0;
                        forced_hold_q <= !cfg_q.an_en;
                    end else if (tmr_q >= 16'(WAKE_MS) || burst_q == 2'h3) begin
                        st_q <= clpm_pkg::CLPM_LOW;
                        tmr_q <= '0;
                    end else if (ms_tick) begin
                        tmr_q <= tmr_q + 16'h1;
                        if (tmr_q % 16'(BURST_MS) == 16'(BURST_MS - 1)) begin
                            burst_q <= burst_q + 2'h1;
                        end
                    end
                end
                default: begin
                    // Forced speed or auto-negotiation off holds normal
                    if (link_up || forced_hold_q || !cfg_q.an_en) begin
                        tmr_q <= '0;
                    end else if (tmr_q >= lto_ms) begin
                        st_q <= clpm_pkg::CLPM_LOW;
                        tmr_q <= '0;
                    end else if (ms_tick) begin
                        tmr_q <= tmr_q + 16'h1;
                    end
                end
            endcase
        end
    end

    // Management stays alive; only datapath blocks are gated
    assign blocks_on = (st_q == clpm_pkg::CLPM_NORMAL) && !cfg_q.pwr_dn;
    assign flp_send = (st_q == clpm_pkg::CLPM_WAKE) && !cfg_q.pwr_dn;
    assign flp_pair_b = burst_q[0];
    assign pwr_state = st_q;
endmodule // clpm_top

/* File: verilog/clpm_pkg.sv */
package clpm_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [11:0] DET_OFF = 12'h008;
    localparam logic [11:0] PDI_OFF = 12'h00c;
    localparam logic [11:0] TMR_OFF = 12'h010;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_AN_EN = 12;
    localparam int CTRL_PWR_DN = 11;
    localparam int CTRL_APD_EN = 6;
    localparam int CTRL_LTO_HI = 7;
    localparam int CTRL_LTO_LO = 2;
    localparam int STAT_LINK = 2;
    localparam int DET_EN = 10;
    localparam int PDI_DET = 9;
    localparam int TMR_SLEEP_LSB = 13;
    localparam int TMR_WAKE_LSB = 11;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_1000;
    localparam logic [31:0] TMR_RST = 32'h0000_2000;
    // ------------------------------------------------------------
    // Timing and detection status codes
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int JIT_NEG_MS = 80;
    localparam int JIT_POS_MS = 60;
    localparam logic [1:0] DET_SEARCH = 2'h0;
    localparam logic [1:0] DET_FOUND = 2'h1;
    localparam logic [1:0] DET_NONE = 2'h2;

    typedef enum logic [1:0] {
        CLPM_LOW,
        CLPM_WAKE,
        CLPM_NORMAL
    } clpm_pwr_t;

    typedef struct packed {
        logic an_en;
        logic pwr_dn;
        logic apd_en;
        logic [1:0] lto_sel;
        logic det_en;
        logic [1:0] sleep_sel;
        logic [1:0] wake_sel;
    } clpm_cfg_t;
endpackage

/* File: verilog/clpm_ms_tick.sv */
`timescale 1ns/1ps
module clpm_ms_tick #(
    parameter int DIV = clpm_pkg::MS_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    output logic tick
);
    logic [31:0] cnt_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (cnt_q == 32'(DIV - 1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    assign tick = (cnt_q == 32'(DIV - 1));
endmodule // clpm_ms_tick

/* File: verif/clpm_partner.sv */
`timescale 1ns/1ps
// ----
// Link partner on the cable
// ----
module clpm_partner (
    input wire logic [1:0] mode,
    input wire logic det_flp_send,
    output logic energy_in,
    output logic loopback_in,
    output logic link_up_in
);
    // Mode 1 is unpowered and only echoes, mode 2 is a live peer
    assign loopback_in = (mode == 2'h1) && det_flp_send;
    assign energy_in = (mode == 2'h2);
    // Link follows the peer alone, so forced speed links too
    assign link_up_in = (mode == 2'h2);
endmodule // clpm_partner

/* File: verif/clpm_top_asserts.sv */
`timescale 1ns/1ps
// ----
// Port checker
// ----
module clpm_top_asserts #(
    parameter int WAKE_MS = 100,
    parameter int MS_DIV = clpm_pkg::MS_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic energy_in,
    input wire logic blocks_on,
    input wire logic flp_send,
    input wire logic det_flp_send,
    input wire logic an_run,
    input wire logic [1:0] pwr_state
);
    // Slack covers the ms tick phase
    localparam int WAKE_MAX = WAKE_MS * MS_DIV + 4;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    AST_RST_LOW: assert property ($rose(reset_n) |-> pwr_state == 2'h0 && !flp_send)
        else $error("power state not low after reset");
    AST_BLOCKS_OFF: assert property (pwr_state != 2'h2 |-> !blocks_on)
        else $error("major blocks on outside normal state");
    AST_FLP_WAKE: assert property (flp_send |-> pwr_state == 2'h1)
        else $error("wake bursts outside wake state");
    AST_DET_AN: assert property (det_flp_send |-> !an_run)
        else $error("detection and auto-negotiation together");
    AST_ENERGY: assert property (energy_in [*4] |-> ##[0:3] pwr_state == 2'h2)
        else $error("energy did not bring normal state");
    AST_WAKE_SRC: assert property ($changed(pwr_state) && pwr_state == 2'h1 |->
        $past(pwr_state) == 2'h0)
        else $error("wake entered from other than low");
    AST_WAKE_LEN: assert property ($changed(pwr_state) && pwr_state == 2'h1 |->
        ##[1:WAKE_MAX] pwr_state != 2'h1)
        else $error("wake state too long");
    AST_PREADY: assert property (psel && penable |-> pready)
        else $error("register access stalled");
endmodule // clpm_top_asserts

bind clpm_top clpm_top_asserts #(.WAKE_MS(WAKE_MS), .MS_DIV(MS_DIV)) u_clpm_top_asserts (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pready(pready), .energy_in(energy_in), .blocks_on(blocks_on), .flp_send(flp_send),
    .det_flp_send(det_flp_send), .an_run(an_run), .pwr_state(pwr_state));

/* File: verif/clpm_top_bench.sv */
`timescale 1ns/1ps
// ----
// Bench
// ----
module clpm_top_bench;
    // One-cycle ms keeps the default sleep and time-out lengths affordable
    localparam int MD = 1;
    localparam int SL [4] = '{1000, 2000, 3000, 4000};
    localparam int LT [4] = '{1000, 2000, 3000, 4000};
    logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic energy_in, loopback_in, link_up_in, blocks_on, flp_send, det_flp_send, an_run;
    logic [1:0] pwr_state, mode, s, r;
    logic flp_pair_b;
    int n_errors, tests_run, n;
    clpm_top #(.WAKE_MS(20), .SEARCH_MS(50), .BURST_MS(4), .MS_DIV(MD)) u_clpm_top (
        .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .energy_in(energy_in), .loopback_in(loopback_in),
        .link_up_in(link_up_in), .blocks_on(blocks_on), .flp_send(flp_send),
        .flp_pair_b(flp_pair_b), .det_flp_send(det_flp_send), .an_run(an_run),
        .pwr_state(pwr_state));
    clpm_partner u_clpm_partner (.mode(mode), .det_flp_send(det_flp_send),
        .energy_in(energy_in), .loopback_in(loopback_in), .link_up_in(link_up_in));
    function automatic logic in_win(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a stalled access
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_st(input logic [1:0] st, output int c);
        c = 0;
        while (pwr_state !== st && c < 10000) begin
            @(posedge core_clk);
            c++;
        end
    endtask
    task automatic do_reset();
        mode <= 2'h0;
        reset_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Whole run is near 27k cycles
    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        stop_test();
    end
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, mode} = '0;
        n_errors = 0;
        tests_run = 0;
        r = 2'($urandom(32'h7bd9138d));
        do_reset();
        apb(0, clpm_pkg::CTRL_OFF, 0);
        chk(rd, clpm_pkg::CTRL_RST);
        apb(0, clpm_pkg::TMR_OFF, 0);
        chk(rd, clpm_pkg::TMR_RST);
        apb(1, 12'h020, 32'h1);
        chk(err, 1);
        $display("reset values done");
        // Auto-negotiation enable is left at its reset value of one
        apb(1, clpm_pkg::DET_OFF, 32'h400);
        apb(0, clpm_pkg::DET_OFF, 0);
        chk(rd, 32'h400);
        chk(det_flp_send, 1);
        mode <= 2'h1;
        repeat (8) @(posedge core_clk);
        apb(0, clpm_pkg::DET_OFF, 0);
        chk(rd, 32'h500);
        apb(0, clpm_pkg::PDI_OFF, 0);
        chk(rd, 32'h200);
        apb(0, clpm_pkg::PDI_OFF, 0);
        chk(rd, 0);
        // Switch powers the port by itself; the peer then comes up live
        mode <= 2'h2;
        repeat (8) @(posedge core_clk);
        apb(0, clpm_pkg::STAT_OFF, 0);
        chk(rd, 32'h4);
        $display("detection found done");
        do_reset();
        apb(1, clpm_pkg::DET_OFF, 32'h400);
        repeat (50 * MD + 20) @(posedge core_clk);
        apb(0, clpm_pkg::DET_OFF, 0);
        chk(rd, 32'h600);
        chk({an_run, det_flp_send}, 2'b10);
        mode <= 2'h2;
        repeat (8) @(posedge core_clk);
        apb(0, clpm_pkg::STAT_OFF, 0);
        chk(rd, 32'h4);
        mode <= 2'h0;
        repeat (8) @(posedge core_clk);
        apb(0, clpm_pkg::DET_OFF, 0);
        chk(rd, 32'h400);
        chk({an_run, det_flp_send}, 2'b01);
        $display("detection timeout done");
        // Every sleep code, from a random start; each code is written during wake
        do_reset();
        apb(1, clpm_pkg::CTRL_OFF, 32'h1040);
        wait_st(2'h1, n);
        for (int i = 0; i < 4; i++) begin
            s = r + 2'(i);
            apb(1, clpm_pkg::TMR_OFF, 32'(s) << 13);
            wait_st(2'h0, n);
            chk(n <= 20 * MD + 4, 1);
            wait_st(2'h1, n);
            chk(in_win(n, (SL[s] - 81) * MD, (SL[s] + 61) * MD + 4), 1);
            chk(flp_send, 1);
            chk(flp_pair_b, 0);
            repeat (5) @(posedge core_clk);
            chk(flp_pair_b, 1);
        end
        $display("sleep cycle done");
        // Every link time-out code
        for (int i = 0; i < 4; i++) begin
            s = r + 2'(i);
            apb(1, clpm_pkg::CTRL_OFF, 32'h1040 | (32'(s[1]) << 7) | (32'(s[0]) << 2));
            mode <= 2'h2;
            wait_st(2'h2, n);
            chk(n < 8, 1);
            chk(blocks_on, 1);
            mode <= 2'h0;
            wait_st(2'h0, n);
            chk(in_win(n, (LT[s] - 1) * MD, (LT[s] + 1) * MD + 8), 1);
        end
        $display("link time-out done");
        // Forced speed from low, then auto-negotiation dropped in normal
        for (int i = 0; i < 2; i++) begin
            do_reset();
            apb(1, clpm_pkg::CTRL_OFF, 32'h1040);
            if (i == 0) begin
                // Reach low first so the forced entry comes from there
                wait_st(2'h0, n);
                apb(1, clpm_pkg::CTRL_OFF, 32'h0040);
            end
            mode <= 2'h2;
            wait_st(2'h2, n);
            chk(n < 8, 1);
            if (i == 1) apb(1, clpm_pkg::CTRL_OFF, 32'h0040);
            mode <= 2'h0;
            repeat ((LT[0] + 50) * MD) @(posedge core_clk);
            chk(pwr_state, 2'h2);
            apb(1, clpm_pkg::CTRL_OFF, 32'h0840);
            chk(blocks_on, 0);
        end
        $display("forced hold done");
        stop_test();
    end
endmodule // clpm_top_bench
